//--- hw/smct_pkg.sv
package smct_pkg;

    // Widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int WAIT_W = 5;
    localparam int FIELD_W = 2;
    localparam int WORD_W = 4 * WAIT_W;
    localparam int CNT_W = WAIT_W + 1;

    // Field codes on the programming port
    localparam logic [FIELD_W-1:0] FIELD_OE_DELAY = 2'h0;
    localparam logic [FIELD_W-1:0] FIELD_RD_LENGTH = 2'h1;
    localparam logic [FIELD_W-1:0] FIELD_WE_DELAY = 2'h2;
    localparam logic [FIELD_W-1:0] FIELD_WR_LENGTH = 2'h3;

    // Field positions inside one bank word
    localparam int OE_DELAY_LSB = 0;
    localparam int RD_LENGTH_LSB = 5;
    localparam int WE_DELAY_LSB = 10;
    localparam int WR_LENGTH_LSB = 15;

    // Reset values of the wait counts
    localparam logic [WAIT_W-1:0] OE_DELAY_RESET = 5'h00;
    localparam logic [WAIT_W-1:0] RD_LENGTH_RESET = 5'h1F;
    localparam logic [WAIT_W-1:0] WE_DELAY_RESET = 5'h00;
    localparam logic [WAIT_W-1:0] WR_LENGTH_RESET = 5'h1F;
    localparam logic [WORD_W-1:0] WORD_RESET = {WR_LENGTH_RESET,
        WE_DELAY_RESET, RD_LENGTH_RESET, OE_DELAY_RESET};

    // Counting constants
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    typedef enum logic [4:0] {
        SMCT_IDLE = 5'b00001,
        SMCT_FETCH = 5'b00010,
        SMCT_LEAD = 5'b00100,
        SMCT_STROBE = 5'b01000,
        SMCT_HOLD = 5'b10000
    } smct_state_type;

endpackage

//--- hw/smct_wait_mem.sv
`timescale 1ns/1ps
`default_nettype none
module smct_wait_mem (
    // System
    input wire logic clk,
    input wire logic arst_n,
    // Field write
    input wire logic wrEn,
    input wire logic [smct_pkg::BANK_W-1:0] wrBank,
    input wire logic [smct_pkg::FIELD_W-1:0] wrField,
    input wire logic [smct_pkg::WAIT_W-1:0] wrValue,
    // Registered word read
    input wire logic [smct_pkg::BANK_W-1:0] rdBank,
    output logic [smct_pkg::WORD_W-1:0] rdWord
);

    logic [smct_pkg::WORD_W-1:0] wordMem_reg [smct_pkg::BANKS];
    logic [smct_pkg::WORD_W-1:0] rdWord_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < smct_pkg::BANKS; i++) begin
                wordMem_reg[i] <= smct_pkg::WORD_RESET;
            end
        end else if (wrEn) begin
            unique case (wrField)
                smct_pkg::FIELD_OE_DELAY: begin
                    wordMem_reg[wrBank][smct_pkg::OE_DELAY_LSB +:
                        smct_pkg::WAIT_W] <= wrValue;
                end
                smct_pkg::FIELD_RD_LENGTH: begin
                    wordMem_reg[wrBank][smct_pkg::RD_LENGTH_LSB +:
                        smct_pkg::WAIT_W] <= wrValue;
                end
                smct_pkg::FIELD_WE_DELAY: begin
                    wordMem_reg[wrBank][smct_pkg::WE_DELAY_LSB +:
                        smct_pkg::WAIT_W] <= wrValue;
                end
                smct_pkg::FIELD_WR_LENGTH: begin
                    wordMem_reg[wrBank][smct_pkg::WR_LENGTH_LSB +:
                        smct_pkg::WAIT_W] <= wrValue;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdWord_reg <= smct_pkg::WORD_RESET;
        end else begin
            rdWord_reg <= wordMem_reg[rdBank];
        end
    end

    assign rdWord = rdWord_reg;

endmodule
`default_nettype wire

//--- hw/smct_top.sv
`timescale 1ns/1ps
`default_nettype none
module smct_top (
    // System
    input wire logic clk,
    input wire logic arst_n,
    // Wait count programming
    input wire logic cfgWrite,
    input wire logic [smct_pkg::BANK_W-1:0] cfgBank,
    input wire logic [smct_pkg::FIELD_W-1:0] cfgField,
    input wire logic [smct_pkg::WAIT_W-1:0] cfgValue,
    // Request side
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [smct_pkg::BANK_W-1:0] reqBank,
    input wire logic [smct_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [smct_pkg::DATA_W-1:0] reqWData,
    input wire logic [smct_pkg::LANES-1:0] reqByteEn,
    output logic reqReady,
    output logic rspValid,
    output logic [smct_pkg::DATA_W-1:0] rspRData,
    output logic busy,
    // Static memory pins
    output logic [smct_pkg::BANKS-1:0] chipSelectN,
    output logic outputEnableN,
    output logic writeEnableN,
    output logic [smct_pkg::LANES-1:0] byteLaneSelectN,
    output logic [smct_pkg::ADDR_W-1:0] memAddr,
    output logic [smct_pkg::DATA_W-1:0] memDataOut,
    output logic memDataOeN,
    input wire logic [smct_pkg::DATA_W-1:0] memDataIn
);

    // Strobe length, never below one cycle
    function automatic logic [smct_pkg::CNT_W-1:0] strobeCycles(
        input logic [smct_pkg::WAIT_W-1:0] delay,
        input logic [smct_pkg::WAIT_W-1:0] len
    );
        logic [smct_pkg::CNT_W-1:0] diff;
        diff = {1'b0, len} - {1'b0, delay} + smct_pkg::CNT_ONE;
        if (len < delay) begin
            diff = smct_pkg::CNT_ONE;
        end
        return diff;
    endfunction

    function automatic logic [smct_pkg::WAIT_W-1:0] waitField(
        input logic [smct_pkg::WORD_W-1:0] word,
        input int lsb
    );
        return word[lsb +: smct_pkg::WAIT_W];
    endfunction

    // One step of a wait counter
    function automatic logic [smct_pkg::CNT_W-1:0] countDown(
        input logic [smct_pkg::CNT_W-1:0] value
    );
        return value - smct_pkg::CNT_ONE;
    endfunction

    smct_pkg::smct_state_type state_reg, state_next;
    logic [smct_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [smct_pkg::CNT_W-1:0] strobeLen_reg, strobeLen_next;
    logic isWrite_reg;
    logic [smct_pkg::BANK_W-1:0] bank_reg;
    logic [smct_pkg::ADDR_W-1:0] addr_reg;
    logic [smct_pkg::DATA_W-1:0] wdata_reg;
    logic [smct_pkg::LANES-1:0] byteEn_reg;
    logic [smct_pkg::WORD_W-1:0] waitWord;
    logic [smct_pkg::CNT_W-1:0] leadCycles;
    logic accept;
    logic strobeStart;
    logic strobeEnd;

    logic reqReady_reg;
    logic rspValid_reg;
    logic [smct_pkg::DATA_W-1:0] rspRData_reg;
    logic busy_reg;
    logic [smct_pkg::BANKS-1:0] chipSelectN_reg;
    logic outputEnableN_reg;
    logic writeEnableN_reg;
    logic [smct_pkg::LANES-1:0] byteLaneSelectN_reg;
    logic [smct_pkg::ADDR_W-1:0] memAddr_reg;
    logic [smct_pkg::DATA_W-1:0] memDataOut_reg;
    logic memDataOeN_reg;

    assign accept = reqValid && reqReady_reg;

    // Bank word arrives one cycle after the accept
    smct_wait_mem waitMem (
        .clk(clk),
        .arst_n(arst_n),
        .wrEn(cfgWrite),
        .wrBank(cfgBank),
        .wrField(cfgField),
        .wrValue(cfgValue),
        .rdBank(reqBank),
        .rdWord(waitWord)
    );

    always_comb begin
        leadCycles = {1'b0, waitField(waitWord, smct_pkg::OE_DELAY_LSB)};
        // write lead is delay plus one
        if (isWrite_reg) begin
            leadCycles = {1'b0, waitField(waitWord,
                smct_pkg::WE_DELAY_LSB)} + smct_pkg::CNT_ONE;
        end
    end

    always_comb begin
        strobeLen_next = strobeCycles(
            waitField(waitWord, smct_pkg::OE_DELAY_LSB),
            waitField(waitWord, smct_pkg::RD_LENGTH_LSB));
        if (isWrite_reg) begin
            strobeLen_next = strobeCycles(
                waitField(waitWord, smct_pkg::WE_DELAY_LSB),
                waitField(waitWord, smct_pkg::WR_LENGTH_LSB));
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            smct_pkg::SMCT_IDLE: begin
                if (accept) begin
                    state_next = smct_pkg::SMCT_FETCH;
                end
            end
            smct_pkg::SMCT_FETCH: begin
                if (leadCycles == smct_pkg::CNT_ZERO) begin
                    state_next = smct_pkg::SMCT_STROBE;
                    cnt_next = countDown(strobeLen_next);
                end else begin
                    state_next = smct_pkg::SMCT_LEAD;
                    cnt_next = countDown(leadCycles);
                end
            end
            smct_pkg::SMCT_LEAD: begin
                if (cnt_reg == smct_pkg::CNT_ZERO) begin
                    state_next = smct_pkg::SMCT_STROBE;
                    cnt_next = countDown(strobeLen_reg);
                end else begin
                    cnt_next = countDown(cnt_reg);
                end
            end
            smct_pkg::SMCT_STROBE: begin
                if (cnt_reg == smct_pkg::CNT_ZERO) begin
                    state_next = smct_pkg::SMCT_HOLD;
                end else begin
                    cnt_next = countDown(cnt_reg);
                end
            end
            smct_pkg::SMCT_HOLD: begin
                state_next = smct_pkg::SMCT_IDLE;
            end
            // Illegal one-hot code falls back to idle
            default: begin
                state_next = smct_pkg::SMCT_IDLE;
            end
        endcase
    end

    assign strobeStart = (state_next == smct_pkg::SMCT_STROBE) &&
        (state_reg != smct_pkg::SMCT_STROBE);
    assign strobeEnd = (state_reg == smct_pkg::SMCT_STROBE) &&
        (state_next == smct_pkg::SMCT_HOLD);

    // Sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= smct_pkg::SMCT_IDLE;
            cnt_reg <= smct_pkg::CNT_ZERO;
            strobeLen_reg <= smct_pkg::CNT_ONE;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (state_reg == smct_pkg::SMCT_FETCH) begin
                strobeLen_reg <= strobeLen_next;
            end
        end
    end

    // Request capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            isWrite_reg <= 1'b0;
            bank_reg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
            byteEn_reg <= '0;
        end else if (accept) begin
            isWrite_reg <= reqWrite;
            bank_reg <= reqBank;
            addr_reg <= reqAddr;
            wdata_reg <= reqWData;
            byteEn_reg <= reqByteEn;
        end
    end

    // Chip select, address and write data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chipSelectN_reg <= '1;
            memAddr_reg <= '0;
            memDataOut_reg <= '0;
            memDataOeN_reg <= 1'b1;
        end else if (state_reg == smct_pkg::SMCT_FETCH) begin
            chipSelectN_reg <= ~(smct_pkg::BANKS'(1) << bank_reg);
            memAddr_reg <= addr_reg;
            if (isWrite_reg) begin
                memDataOut_reg <= wdata_reg;
                memDataOeN_reg <= 1'b0;
            end
        end else if (strobeEnd && !isWrite_reg) begin
            chipSelectN_reg <= '1;
        end else if (state_reg == smct_pkg::SMCT_HOLD) begin
            chipSelectN_reg <= '1;
            memDataOeN_reg <= 1'b1;
        end
    end

    // Strobes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            outputEnableN_reg <= 1'b1;
            writeEnableN_reg <= 1'b1;
            byteLaneSelectN_reg <= '1;
        end else if (strobeStart) begin
            if (isWrite_reg) begin
                writeEnableN_reg <= 1'b0;
                byteLaneSelectN_reg <= ~byteEn_reg;
            end else begin
                outputEnableN_reg <= 1'b0;
                byteLaneSelectN_reg <= '0;
            end
        end else if (strobeEnd) begin
            outputEnableN_reg <= 1'b1;
            writeEnableN_reg <= 1'b1;
            byteLaneSelectN_reg <= '1;
        end
    end

    // Request handshake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reqReady_reg <= 1'b1;
            busy_reg <= 1'b0;
        end else begin
            reqReady_reg <= (state_next == smct_pkg::SMCT_IDLE);
            busy_reg <= (state_next != smct_pkg::SMCT_IDLE);
        end
    end

    // Access answer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rspValid_reg <= 1'b0;
            rspRData_reg <= '0;
        end else begin
            rspValid_reg <= (state_reg == smct_pkg::SMCT_HOLD);
            if (strobeEnd && !isWrite_reg) begin
                rspRData_reg <= memDataIn;
            end
        end
    end

    assign reqReady = reqReady_reg;
    assign rspValid = rspValid_reg;
    assign rspRData = rspRData_reg;
    assign busy = busy_reg;
    assign chipSelectN = chipSelectN_reg;
    assign outputEnableN = outputEnableN_reg;
    assign writeEnableN = writeEnableN_reg;
    assign byteLaneSelectN = byteLaneSelectN_reg;
    assign memAddr = memAddr_reg;
    assign memDataOut = memDataOut_reg;
    assign memDataOeN = memDataOeN_reg;

endmodule
`default_nettype wire

//--- test/smct_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smct_checker (
    // System
    input wire logic clk,
    input wire logic arst_n,
    // Request side
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [smct_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [smct_pkg::DATA_W-1:0] reqWData,
    input wire logic [smct_pkg::LANES-1:0] reqByteEn,
    // Memory pins
    input wire logic [smct_pkg::BANKS-1:0] chipSelectN,
    input wire logic outputEnableN,
    input wire logic writeEnableN,
    input wire logic [smct_pkg::LANES-1:0] byteLaneSelectN,
    input wire logic [smct_pkg::ADDR_W-1:0] memAddr,
    input wire logic [smct_pkg::DATA_W-1:0] memDataOut,
    input wire logic memDataOeN
);
    logic [smct_pkg::ADDR_W-1:0] takenAddr_reg;
    logic [smct_pkg::DATA_W-1:0] takenData_reg;
    logic [smct_pkg::LANES-1:0] takenLanes_reg;
    wire logic csIdle = &chipSelectN;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Request as taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            takenAddr_reg <= 24'h0;
            takenData_reg <= 32'h0;
            takenLanes_reg <= 4'h0;
        end else if (reqValid && reqReady) begin
            takenAddr_reg <= reqAddr;
            takenData_reg <= reqWData;
            takenLanes_reg <= reqByteEn;
        end
    end
    addr_at_select_a: assert property (
        $fell(csIdle) |-> memAddr == takenAddr_reg)
        else $error("address late");
    data_at_select_a: assert property (
        $fell(csIdle) && !memDataOeN |-> memDataOut == takenData_reg)
        else $error("write data late");
    lanes_with_oe_a: assert property (
        $fell(outputEnableN) |-> byteLaneSelectN == 4'h0 && !csIdle)
        else $error("lanes not with output enable");
    read_end_together_a: assert property (
        $rose(outputEnableN) |-> csIdle && &byteLaneSelectN)
        else $error("read end not together");
    read_addr_hold_a: assert property (
        $rose(outputEnableN) |=> $stable(memAddr))
        else $error("read address not held");
    write_lanes_a: assert property (
        $fell(writeEnableN) |-> byteLaneSelectN == ~takenLanes_reg
        && !memDataOeN)
        else $error("write lanes wrong");
    write_lead_a: assert property (
        $fell(csIdle) |-> writeEnableN) else $error("write enable early");
    write_hold_a: assert property (
        $rose(writeEnableN) |-> $stable(memAddr) && $stable(memDataOut)
        && !csIdle && !memDataOeN) else $error("write hold missing");
    lane_hold_a: assert property (
        $rose(&byteLaneSelectN) && !memDataOeN |=> $stable(memDataOut)
        && $stable(memAddr)) else $error("lane hold missing");
endmodule
bind smct_top smct_checker u_chk (.clk, .arst_n, .reqValid, .reqReady,
    .reqAddr, .reqWData, .reqByteEn, .chipSelectN, .outputEnableN,
    .writeEnableN, .byteLaneSelectN, .memAddr, .memDataOut, .memDataOeN);
`default_nettype wire

//--- test/smct_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module smct_sram_model (
    // System
    input wire logic clk,
    // Memory pins
    input wire logic [smct_pkg::BANKS-1:0] chipSelectN,
    input wire logic outputEnableN,
    input wire logic writeEnableN,
    input wire logic [smct_pkg::LANES-1:0] byteLaneSelectN,
    input wire logic [smct_pkg::ADDR_W-1:0] memAddr,
    input wire logic [smct_pkg::DATA_W-1:0] memDataOut,
    input wire logic memDataOeN,
    output logic [smct_pkg::DATA_W-1:0] memDataIn
);
    logic [31:0] mem [16];
    logic [31:0] idlePat;
    initial begin
        idlePat = 32'h5A5A5A5A;
        foreach (mem[i]) mem[i] = 32'h0;
    end
    // Undriven pins show a changing pattern
    assign memDataIn = (!(&chipSelectN) && !outputEnableN) ?
        mem[memAddr[3:0]] : idlePat;
    always @(posedge clk) begin
        idlePat <= idlePat + 32'h9E3779B9;
        if (!(&chipSelectN) && !writeEnableN && !memDataOeN) begin
            for (int i = 0; i < 4; i++) begin
                if (!byteLaneSelectN[i]) begin
                    mem[memAddr[3:0]][8*i +: 8] <= memDataOut[8*i +: 8];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb_static_memory_cycle_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_static_memory_cycle_timing;
    typedef struct {
        logic w; logic [1:0] b; logic [4:0] oe, rd, we, wl;
        logic [23:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] r;
    } smct_row_type;
    smct_row_type rows [6] = '{
        '{1'b1, 2'h0, 5'h00, 5'h00, 5'h00, 5'h01,
            24'h1, 32'h11223344, 4'hF, 32'h0},
        '{1'b0, 2'h0, 5'h01, 5'h02, 5'h00, 5'h01,
            24'h1, 32'h0, 4'h0, 32'h11223344},
        '{1'b1, 2'h1, 5'h00, 5'h00, 5'h03, 5'h03,
            24'h2, 32'hA5A5A5A5, 4'h5, 32'h0},
        '{1'b0, 2'h1, 5'h00, 5'h00, 5'h03, 5'h03,
            24'h2, 32'h0, 4'h0, 32'h00A500A5},
        '{1'b1, 2'h2, 5'h00, 5'h00, 5'h02, 5'h06,
            24'h3, 32'h0F0F0F0F, 4'hF, 32'h0},
        '{1'b0, 2'h3, 5'h04, 5'h09, 5'h00, 5'h01,
            24'h3, 32'h0, 4'h0, 32'h0F0F0F0F}};
    logic clk = 1'b0, arst_n = 1'b0, cfgWrite = 1'b0, reqValid = 1'b0;
    logic reqWrite = 1'b0, reqReady, rspValid, busy, outputEnableN;
    logic writeEnableN, memDataOeN;
    logic [1:0] cfgBank = 2'h0, cfgField = 2'h0, reqBank = 2'h0;
    logic [4:0] cfgValue = 5'h00;
    logic [23:0] reqAddr = 24'h0, memAddr;
    logic [31:0] reqWData = 32'h0, rspRData, memDataOut, memDataIn;
    logic [3:0] reqByteEn = 4'h0, chipSelectN, byteLaneSelectN;
    int fails = 0, compares = 0;
    smct_top uut (.clk(clk), .arst_n(arst_n), .cfgWrite(cfgWrite),
        .cfgBank(cfgBank), .cfgField(cfgField), .cfgValue(cfgValue),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqBank(reqBank),
        .reqAddr(reqAddr), .reqWData(reqWData), .reqByteEn(reqByteEn),
        .reqReady(reqReady), .rspValid(rspValid), .rspRData(rspRData),
        .busy(busy), .chipSelectN(chipSelectN), .outputEnableN(outputEnableN),
        .writeEnableN(writeEnableN), .byteLaneSelectN(byteLaneSelectN),
        .memAddr(memAddr), .memDataOut(memDataOut), .memDataOeN(memDataOeN),
        .memDataIn(memDataIn));
    smct_sram_model mem (.clk(clk), .chipSelectN(chipSelectN),
        .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
        .byteLaneSelectN(byteLaneSelectN), .memAddr(memAddr),
        .memDataOut(memDataOut), .memDataOeN(memDataOeN),
        .memDataIn(memDataIn));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic int lenOf(input int dly, input int len);
        return (len >= dly) ? len - dly + 1 : 1;
    endfunction
    task automatic prog(input logic [1:0] b, input logic [4:0] v [4]);
        for (int f = 0; f < 4; f++) begin
            @(negedge clk);
            cfgWrite = 1'b1;
            cfgBank = b;
            cfgField = 2'(f);
            cfgValue = v[f];
            @(negedge clk);
            cfgWrite = 1'b0;
        end
    endtask
    task automatic doReset();
        @(negedge clk);
        arst_n = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        check("chipSelectN", {28'h0, chipSelectN}, 32'hF);
        check("strobesN", {29'h0, outputEnableN, writeEnableN, memDataOeN},
            32'h7);
        check("idleFlags", {29'h0, reqReady, busy, rspValid}, 32'h4);
    endtask
    task automatic access(input logic w, input logic [1:0] b,
            input logic [23:0] a, input logic [31:0] d, input logic [3:0] be,
            input int expD, input int expL, input logic [31:0] expR);
        int tc, ts, te;
        logic stb;
        tc = -1;
        ts = -1;
        te = -1;
        @(negedge clk);
        check("rspPulse", {31'h0, rspValid}, 32'h0);
        reqValid = 1'b1;
        reqWrite = w;
        reqBank = b;
        reqAddr = a;
        reqWData = d;
        reqByteEn = be;
        @(negedge clk);
        reqValid = 1'b0;
        check("acceptFlags", {30'h0, reqReady, busy}, 32'h1);
        for (int n = 0; n < 200 && rspValid !== 1'b1; n++) begin
            stb = w ? writeEnableN : outputEnableN;
            if (tc < 0 && chipSelectN[b] === 1'b0) tc = n;
            if (ts < 0 && stb === 1'b0) ts = n;
            if (ts >= 0 && te < 0 && stb === 1'b1) te = n;
            @(negedge clk);
        end
        check("rspValid", {31'h0, rspValid}, 32'h1);
        check("endFlags", {30'h0, reqReady, busy}, 32'h2);
        check("strobeDelay", 32'(ts - tc), 32'(expD));
        check("strobeLength", 32'(te - ts), 32'(expL));
        check("memAddr", {8'h0, memAddr}, {8'h0, a});
        if (!w) check("rspRData", rspRData, expR);
    endtask
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
    initial begin
        logic [4:0] v [4];
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        check("reqReady", {31'h0, reqReady}, 32'h1);
        foreach (rows[i]) begin
            v = '{rows[i].oe, rows[i].rd, rows[i].we, rows[i].wl};
            prog(rows[i].b, v);
            if (rows[i].w) access(1'b1, rows[i].b, rows[i].a, rows[i].d,
                rows[i].be, rows[i].we + 1, lenOf(rows[i].we, rows[i].wl),
                32'h0);
            else access(1'b0, rows[i].b, rows[i].a, 32'h0, 4'h0, rows[i].oe,
                lenOf(rows[i].oe, rows[i].rd), rows[i].r);
        end
        // Delay above length clamps the strobe
        v = '{5'h05, 5'h02, 5'h00, 5'h1F};
        prog(2'h2, v);
        access(1'b0, 2'h2, 24'h3, 32'h0, 4'h0, 5, 1, 32'h0F0F0F0F);
        // Bank 0 keeps its own counts
        access(1'b0, 2'h0, 24'h1, 32'h0, 4'h0, 1, 2, 32'h11223344);
        doReset();
        access(1'b0, 2'h0, 24'h1, 32'h0, 4'h0, 0, 32, 32'h11223344);
        give_verdict();
    end
endmodule
`default_nettype wire
